// ---- pkg/axis_stop_regs.svh ----
`ifndef AXIS_STOP_REGS_SVH
`define AXIS_STOP_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define REG_CMD          8'h00
`define REG_TARGET_SPEED 8'h04
`define REG_DECEL_TIME   8'h08
`define REG_RAPID_TIME   8'h0C
`define REG_DWELL_TIME   8'h10
`define REG_STATUS       8'h14
`define REG_MINOR_ERR    8'h18
`define REG_IRQ_STAT     8'h1C
`define REG_IRQ_MASK     8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CMD_STOP_BIT     0
`define CMD_RAPID_BIT    1
`define CMD_START_BIT    2
`define CMD_MODE_LSB     4
`define CMD_MODE_MSB     6
`define STAT_ACC_BIT     0
`define STAT_DONE_BIT    1
`define STAT_STATE_LSB   4
`define STAT_STATE_MSB   6
`define STAT_SPEED_LSB   16
`define IRQ_WIDTH        4

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define RST_TIME         16'h0064
`define RST_SPEED        16'h0000
`define RST_IRQ_MASK     4'h0
`define ERR_NONE         16'h0000
`define ERR_HOME_STOP    16'h00CB

// ----------------------------------------------------------------------
// Timing: times are in milliseconds, counted by a 1 ms tick
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS    40
`define TICK_PERIOD_NS   1000000
`define TICK_CYCLES      (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ---- pkg/axis_stop_pkg.sv ----
package axis_stop_pkg;

    typedef enum logic [2:0] {
        MODE_POSITION     = 3'b000,
        MODE_SPEED        = 3'b001,
        MODE_JOG          = 3'b010,
        MODE_SPEED_FIXED  = 3'b011,
        MODE_MPG          = 3'b100,
        MODE_HOME         = 3'b101,
        MODE_SPEED_TORQUE = 3'b110,
        MODE_SPARE        = 3'b111
    } mode_t;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_RUN       = 3'b001,
        ST_DECEL     = 3'b010,
        ST_RAPID     = 3'b011,
        ST_DWELL     = 3'b100,
        ST_ZERO_WAIT = 3'b101
    } axis_state_t;

    typedef struct packed {
        mode_t mode;
        logic  rapid;
        logic  stop;
    } cmd_t;

    typedef struct packed {
        logic pos_done;
        logic start_refused;
        logic home_err;
        logic stop_done;
    } irq_t;

endpackage

// ---- logic/speed_ramp.sv ----
`timescale 1ns/1ps
`include "axis_stop_regs.svh"

module speed_ramp #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         tick_i,
    input  wire logic         set_i,
    input  wire logic [W-1:0] set_val_i,
    input  wire logic         ramp_i,
    input  wire logic [15:0]  ramp_time_i,
    output logic      [W-1:0] speed_o,
    output logic              busy_o
);
    logic [W-1:0] start_reg;
    logic [15:0]  time_reg;
    logic [15:0]  remain_reg;
    logic [31:0]  acc_reg;

    // ------------------------------------------------------------------
    // Linear ramp to zero: accumulated start speed paid out per time unit
    // ------------------------------------------------------------------
    wire pay_out = busy_o && !tick_i && (acc_reg >= {16'h0000, time_reg}) && (speed_o != '0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            speed_o    <= '0;
            busy_o     <= 1'b0;
            start_reg  <= '0;
            time_reg   <= 16'h0000;
            remain_reg <= 16'h0000;
            acc_reg    <= 32'h0000_0000;
        end else if (set_i) begin
            speed_o <= set_val_i;
            busy_o  <= 1'b0;
        end else if (ramp_i) begin
            start_reg  <= speed_o;
            time_reg   <= ramp_time_i;
            remain_reg <= ramp_time_i;
            acc_reg    <= 32'h0000_0000;
            busy_o     <= (ramp_time_i != 16'h0000);
            if (ramp_time_i == 16'h0000) begin
                speed_o <= '0;
            end
        end else if (busy_o && tick_i) begin
            acc_reg    <= acc_reg + 32'(start_reg);
            remain_reg <= remain_reg - 16'h0001;
            if (remain_reg == 16'h0001) begin
                speed_o <= '0;
                busy_o  <= 1'b0;
            end
        end else if (pay_out) begin
            acc_reg <= acc_reg - {16'h0000, time_reg};
            speed_o <= speed_o - W'(1);
        end
    end
endmodule // speed_ramp

// ---- logic/axis_rapid_stop_handler.sv ----
// Behaviour
// - Rapid stop acts on rising edge only
// - Start refused while rapid stop held on
// - Ramp modes decelerate over rapid stop time
// - Rapid stop overrides running deceleration stop
// - Pulse generator mode halts at once
// - Home return ramps over rapid stop time
// - Home return rapid stop stores error 203
// - Speed-torque mode commands zero speed
// - Zero speed seen: switch to position control
// - Rapid stop ignored during dwell
// - Stop ignored in dwell; end sets flags
`timescale 1ns/1ps
`include "axis_stop_regs.svh"

module axis_rapid_stop_handler
    import axis_stop_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int SPEED_W     = 16
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [7:0]         adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    output logic      [31:0]        dat_o,
    output logic                    ack_o,
    input  wire logic               in_position_i,
    input  wire logic               zero_speed_i,
    output logic      [SPEED_W-1:0] speed_cmd_o,
    output logic                    irq_o
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    cmd_t          cmd_reg;
    logic          rapid_q_reg;
    logic          stop_q_reg;
    logic [15:0]   target_reg;
    logic [15:0]   decel_time_reg;
    logic [15:0]   rapid_time_reg;
    logic [15:0]   dwell_time_reg;
    logic [15:0]   minor_err_reg;
    logic [15:0]   dwell_cnt_reg;
    irq_t          irq_stat_reg;
    irq_t          irq_mask_reg;
    axis_state_t   state_reg;
    axis_state_t   state_next;
    logic          start_acc_reg;
    logic          done_reg;
    logic [31:0]   tick_cnt_reg;
    logic          tick_reg;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire        bus_req    = cyc_i && stb_i && !ack_o;
    wire        wr_req     = bus_req && we_i;
    wire        rd_req     = bus_req && !we_i;
    wire        lo_lane    = sel_i[0];
    wire        wr_cmd     = wr_req && adr_i == `REG_CMD && lo_lane;
    wire        wr_target  = wr_req && adr_i == `REG_TARGET_SPEED;
    wire        wr_decel   = wr_req && adr_i == `REG_DECEL_TIME;
    wire        wr_rapid_t = wr_req && adr_i == `REG_RAPID_TIME;
    wire        wr_dwell   = wr_req && adr_i == `REG_DWELL_TIME;
    wire        wr_err     = wr_req && adr_i == `REG_MINOR_ERR;
    wire        wr_mask    = wr_req && adr_i == `REG_IRQ_MASK && lo_lane;
    wire        rd_irq     = rd_req && adr_i == `REG_IRQ_STAT;
    wire        start_wr   = wr_cmd && dat_i[`CMD_START_BIT];

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  lanes);
        merge16 = {lanes[1] ? new_v[15:8] : old_v[15:8],
                   lanes[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction

    // ------------------------------------------------------------------
    // Command edges and mode classes
    // ------------------------------------------------------------------
    wire rapid_rise = cmd_reg.rapid && !rapid_q_reg;
    wire stop_rise  = cmd_reg.stop && !stop_q_reg;
    wire ramp_mode  = cmd_reg.mode inside {MODE_POSITION, MODE_SPEED, MODE_JOG,
                                           MODE_SPEED_FIXED};
    wire moving     = state_reg == ST_RUN || state_reg == ST_DECEL;
    wire dwell_end  = state_reg == ST_DWELL && dwell_cnt_reg == 16'h0000;
    wire start_go   = start_wr && state_reg == ST_IDLE && !cmd_reg.rapid;
    wire start_bad  = start_wr && cmd_reg.rapid;
    wire home_err   = rapid_rise && moving && cmd_reg.mode == MODE_HOME;
    wire ramp_busy;
    wire [SPEED_W-1:0] speed_now;

    // ------------------------------------------------------------------
    // Stop handling
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (start_go) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN, ST_DECEL: begin
                if (rapid_rise) begin
                    if (cmd_reg.mode == MODE_SPEED_TORQUE) begin
                        state_next = ST_ZERO_WAIT;
                    end else if (cmd_reg.mode == MODE_MPG) begin
                        state_next = ST_IDLE;
                    end else begin
                        state_next = ST_RAPID;
                    end
                end else if (state_reg == ST_RUN && stop_rise) begin
                    state_next = (cmd_reg.mode == MODE_SPEED_TORQUE) ? ST_ZERO_WAIT
                                                                      : ST_DECEL;
                end else if (state_reg == ST_RUN && in_position_i) begin
                    state_next = ST_DWELL;
                end else if (state_reg == ST_DECEL && !ramp_busy) begin
                    state_next = ST_IDLE;
                end
            end
            ST_RAPID: begin
                if (!ramp_busy) begin
                    state_next = ST_IDLE;
                end
            end
            ST_DWELL: begin
                if (dwell_end) begin
                    state_next = ST_IDLE;
                end
            end
            ST_ZERO_WAIT: begin
                if (zero_speed_i) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    wire enter_rapid = rapid_rise && moving && cmd_reg.mode != MODE_MPG
                       && cmd_reg.mode != MODE_SPEED_TORQUE;
    wire enter_decel = state_reg == ST_RUN && stop_rise && !rapid_rise
                       && cmd_reg.mode != MODE_SPEED_TORQUE;
    wire zero_now    = moving && (rapid_rise || stop_rise)
                       && (cmd_reg.mode == MODE_MPG || cmd_reg.mode == MODE_SPEED_TORQUE)
                       && !(cmd_reg.mode == MODE_MPG && !rapid_rise);
    wire ramp_set    = start_go || zero_now;
    wire ramp_go     = enter_rapid || enter_decel;
    wire [15:0] ramp_time = enter_rapid ? rapid_time_reg : decel_time_reg;
    wire stop_done   = (state_reg == ST_RAPID || state_reg == ST_DECEL)
                       && state_next == ST_IDLE;
    irq_t irq_event;
    assign irq_event = '{pos_done: dwell_end, start_refused: start_bad,
                         home_err: home_err, stop_done: stop_done};
    wire [`IRQ_WIDTH-1:0] irq_stat_next = (rd_irq ? '0 : irq_stat_reg) | irq_event;

    speed_ramp #(
        .W (SPEED_W)
    ) u_ramp (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .tick_i      (tick_reg),
        .set_i       (ramp_set),
        .set_val_i   (start_go ? SPEED_W'(target_reg) : '0),
        .ramp_i      (ramp_go),
        .ramp_time_i (ramp_time),
        .speed_o     (speed_now),
        .busy_o      (ramp_busy)
    );
    assign speed_cmd_o = speed_now;

    // ------------------------------------------------------------------
    // Millisecond tick and axis state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
        end
        tick_reg <= !rst_i && tick_cnt_reg == 32'(TICK_CYCLES - 1);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg     <= ST_IDLE;
            rapid_q_reg   <= 1'b0;
            stop_q_reg    <= 1'b0;
            dwell_cnt_reg <= 16'h0000;
            start_acc_reg <= 1'b0;
            done_reg      <= 1'b0;
        end else begin
            state_reg   <= state_next;
            rapid_q_reg <= cmd_reg.rapid;
            stop_q_reg  <= cmd_reg.stop;
            if (state_next == ST_DWELL && state_reg != ST_DWELL) begin
                dwell_cnt_reg <= dwell_time_reg;
            end else if (tick_reg && dwell_cnt_reg != 16'h0000) begin
                dwell_cnt_reg <= dwell_cnt_reg - 16'h0001;
            end
            if (start_go) begin
                start_acc_reg <= 1'b1;
                done_reg      <= 1'b0;
            end else if (dwell_end) begin
                start_acc_reg <= 1'b0;
                done_reg      <= 1'b1;
            end else if (state_next == ST_IDLE) begin
                start_acc_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_reg        <= '{mode: MODE_POSITION, rapid: 1'b0, stop: 1'b0};
            target_reg     <= `RST_SPEED;
            decel_time_reg <= `RST_TIME;
            rapid_time_reg <= `RST_TIME;
            dwell_time_reg <= `RST_TIME;
            irq_mask_reg   <= `RST_IRQ_MASK;
        end else begin
            if (state_reg == ST_ZERO_WAIT && zero_speed_i) begin
                cmd_reg.mode <= MODE_POSITION;
            end else if (wr_cmd) begin
                cmd_reg.mode <= mode_t'(dat_i[`CMD_MODE_MSB:`CMD_MODE_LSB]);
            end
            if (wr_cmd) begin
                cmd_reg.rapid <= dat_i[`CMD_RAPID_BIT];
                cmd_reg.stop  <= dat_i[`CMD_STOP_BIT];
            end
            if (wr_target) target_reg <= merge16(target_reg, dat_i, sel_i);
            if (wr_decel) decel_time_reg <= merge16(decel_time_reg, dat_i, sel_i);
            if (wr_rapid_t) rapid_time_reg <= merge16(rapid_time_reg, dat_i, sel_i);
            if (wr_dwell) dwell_time_reg <= merge16(dwell_time_reg, dat_i, sel_i);
            if (wr_mask) irq_mask_reg <= irq_t'(dat_i[`IRQ_WIDTH-1:0]);
        end
    end

    // Event bits: a new event wins over a clearing access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            minor_err_reg <= `ERR_NONE;
            irq_stat_reg  <= '0;
            irq_o         <= 1'b0;
        end else begin
            if (home_err) begin
                minor_err_reg <= `ERR_HOME_STOP;
            end else if (wr_err) begin
                minor_err_reg <= `ERR_NONE;
            end
            irq_stat_reg <= irq_t'(irq_stat_next);
            irq_o        <= |(irq_stat_next & (wr_mask ? dat_i[`IRQ_WIDTH-1:0] : irq_mask_reg));
        end
    end

    wire [31:0] status_word = {16'(speed_now), 9'h000, state_reg, 2'b00,
                               done_reg, start_acc_reg};
    wire [31:0] rd_mux =
        adr_i == `REG_CMD          ? {25'h0, cmd_reg.mode, 2'b00, cmd_reg.rapid,
                                      cmd_reg.stop} :
        adr_i == `REG_TARGET_SPEED ? {16'h0000, target_reg} :
        adr_i == `REG_DECEL_TIME   ? {16'h0000, decel_time_reg} :
        adr_i == `REG_RAPID_TIME   ? {16'h0000, rapid_time_reg} :
        adr_i == `REG_DWELL_TIME   ? {16'h0000, dwell_time_reg} :
        adr_i == `REG_STATUS       ? status_word :
        adr_i == `REG_MINOR_ERR    ? {16'h0000, minor_err_reg} :
        adr_i == `REG_IRQ_STAT     ? {28'h0, irq_stat_reg} :
        adr_i == `REG_IRQ_MASK     ? {28'h0, irq_mask_reg} : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req;
            dat_o <= rd_req ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_EDGE_ONLY: assert property (
        (state_reg != ST_RAPID ##1 state_reg == ST_RAPID) |-> $past(rapid_rise))
        else $error("rapid ramp entered without a rising command");
    AST_START_REFUSED: assert property (
        (start_wr && cmd_reg.rapid) |=> state_reg == ST_IDLE && !start_acc_reg)
        else $error("axis started while rapid stop held");
    AST_RAPID_RAMP: assert property (
        (rapid_rise && state_reg == ST_RUN && ramp_mode) |=> state_reg == ST_RAPID)
        else $error("ramp mode did not enter rapid stop");
    AST_ABANDON_DECEL: assert property (
        (rapid_rise && state_reg == ST_DECEL && ramp_mode) |=> state_reg == ST_RAPID)
        else $error("deceleration not replaced by rapid stop");
    AST_MPG_HALT: assert property (
        (rapid_rise && moving && cmd_reg.mode == MODE_MPG)
        |=> speed_cmd_o == '0 && state_reg == ST_IDLE)
        else $error("pulse generator axis not halted at once");
    AST_HOME_RAMP: assert property (
        (rapid_rise && moving && cmd_reg.mode == MODE_HOME)
        |=> state_reg == ST_RAPID && ramp_busy == (rapid_time_reg != 16'h0000))
        else $error("home return did not ramp over rapid time");
    AST_HOME_ERR: assert property (
        home_err |=> minor_err_reg == `ERR_HOME_STOP)
        else $error("home return error code not stored");
    AST_ZERO_SPEED: assert property (
        (rapid_rise && moving && cmd_reg.mode == MODE_SPEED_TORQUE)
        |=> speed_cmd_o == '0 && state_reg == ST_ZERO_WAIT)
        else $error("speed-torque axis not commanded to zero");
    AST_TO_POSITION: assert property (
        (state_reg == ST_ZERO_WAIT && zero_speed_i)
        |=> cmd_reg.mode == MODE_POSITION && state_reg == ST_IDLE)
        else $error("no switch to position control at zero speed");
    AST_DWELL_IGNORE: assert property (
        (state_reg == ST_DWELL && !dwell_end && (rapid_rise || stop_rise))
        |=> state_reg == ST_DWELL)
        else $error("stop command acted during dwell");
    AST_DWELL_END: assert property (
        dwell_end |=> !start_acc_reg && done_reg && state_reg == ST_IDLE)
        else $error("dwell end flags wrong");

    COV_RAPID: cover property (state_reg == ST_RAPID ##1 state_reg == ST_IDLE);
    COV_ABANDON: cover property (state_reg == ST_DECEL ##1 state_reg == ST_RAPID);
    COV_TORQUE: cover property (state_reg == ST_ZERO_WAIT ##1 state_reg == ST_IDLE);
    COV_DWELL: cover property (dwell_end);
endmodule // axis_rapid_stop_handler

// ---- test/servo_model.sv ----
`timescale 1ns/1ps

module servo_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] speed_i,
    input  wire logic        reach_i,
    output logic             in_position_o,
    output logic             zero_speed_o
);
    // Zero speed reported one cycle after command reaches zero
    always_ff @(posedge clk_i) begin
        zero_speed_o <= (speed_i == 16'h0000);
    end
    assign in_position_o = reach_i;
endmodule // servo_model

// ---- test/axis_rapid_stop_handler_tb_top.sv ----
`timescale 1ns/1ps
`include "axis_stop_regs.svh"

module axis_rapid_stop_handler_tb_top
    import axis_stop_pkg::*;
;
    typedef struct packed {
        mode_t       m;
        logic        ramp;
        logic [15:0] err;
    } row_t;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic        reach = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] rd;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        irq_o;
    logic [15:0] speed_cmd_o;
    wire         in_pos;
    wire         zero_spd;
    int          failures  = 0;
    int          cmp_count = 0;
    row_t        rows [7]  = '{
        '{MODE_POSITION, 1'b1, `ERR_NONE}, '{MODE_SPEED, 1'b1, `ERR_NONE},
        '{MODE_JOG, 1'b1, `ERR_NONE}, '{MODE_SPEED_FIXED, 1'b1, `ERR_NONE},
        '{MODE_MPG, 1'b0, `ERR_NONE}, '{MODE_HOME, 1'b1, `ERR_HOME_STOP},
        '{MODE_SPEED_TORQUE, 1'b0, `ERR_NONE}};

    always #20 clk_i = ~clk_i;

    axis_rapid_stop_handler #(.TICK_CYCLES(4), .SPEED_W(16)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .in_position_i(in_pos), .zero_speed_i(zero_spd), .speed_cmd_o(speed_cmd_o),
        .irq_o(irq_o));

    servo_model u_servo (
        .clk_i(clk_i), .speed_i(speed_cmd_o), .reach_i(reach),
        .in_position_o(in_pos), .zero_speed_o(zero_spd));

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1) failures++;
        q = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin wb(1'b0, `REG_STATUS, 32'h0, rd); n++; end
        while (rd[6:4] !== 3'h0 && n < 300);
        if (rd[6:4] !== 3'h0) failures++;
    endtask

    task end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [2:0] em;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, `REG_RAPID_TIME, 32'h0, rd); chk("rapid_time", 32'h64, rd);
        wb(1'b0, 8'h40, 32'h0, rd); chk("unmapped", 32'h0, rd);
        wb(1'b1, `REG_RAPID_TIME, 32'h3, rd);
        wb(1'b1, `REG_TARGET_SPEED, 32'h40, rd);
        wb(1'b1, `REG_DECEL_TIME, 32'h32, rd);
        wb(1'b1, `REG_DWELL_TIME, 32'h8, rd);
        for (int i = 0; i < 7; i++) begin
            em = (rows[i].m == MODE_SPEED_TORQUE) ? MODE_POSITION : rows[i].m;
            wb(1'b1, `REG_CMD, {25'h0, rows[i].m, 4'h4}, rd);
            wb(1'b0, `REG_STATUS, 32'h0, rd);
            chk("started", 32'h00400001, rd & 32'hFFFF0001);
            wb(1'b1, `REG_CMD, {25'h0, rows[i].m, 4'h2}, rd);
            wb(1'b0, `REG_STATUS, 32'h0, rd);
            chk("ramping", {31'h0, rows[i].ramp}, {31'h0, rd[31:16] != 16'h0});
            wait_idle();
            chk("stopped", 32'h0, rd & 32'hFFFF0001);
            wb(1'b0, `REG_MINOR_ERR, 32'h0, rd);
            chk("minor_err", {16'h0, rows[i].err}, rd);
            wb(1'b0, `REG_CMD, 32'h0, rd);
            chk("mode", {29'h0, em}, {29'h0, rd[6:4]});
            wb(1'b1, `REG_CMD, {25'h0, em, 4'h0}, rd);
            wb(1'b1, `REG_MINOR_ERR, 32'h0, rd);
        end
        // Host repeats the home return after its rapid stop
        wb(1'b1, `REG_CMD, {25'h0, MODE_HOME, 4'h4}, rd);
        wb(1'b0, `REG_STATUS, 32'h0, rd);
        chk("home_again", 32'h00400001, rd & 32'hFFFF0001);
        // Rapid stop overrides a running deceleration stop
        wb(1'b1, `REG_CMD, 32'h4, rd);
        wb(1'b1, `REG_CMD, 32'h1, rd);
        wb(1'b0, `REG_STATUS, 32'h0, rd); chk("decel", 32'h2, {29'h0, rd[6:4]});
        wb(1'b1, `REG_CMD, 32'h3, rd);
        wb(1'b0, `REG_STATUS, 32'h0, rd); chk("override", 32'h3, {29'h0, rd[6:4]});
        wait_idle();
        wb(1'b1, `REG_CMD, 32'h0, rd);
        // Both stop commands ignored in dwell
        wb(1'b1, `REG_CMD, 32'h4, rd);
        reach <= 1'b1;
        repeat (2) @(posedge clk_i);
        reach <= 1'b0;
        wb(1'b1, `REG_CMD, 32'h2, rd);
        wb(1'b1, `REG_CMD, 32'h3, rd);
        wb(1'b0, `REG_STATUS, 32'h0, rd); chk("dwell", 32'h4, {29'h0, rd[6:4]});
        wait_idle();
        chk("dwell_end", 32'h2, rd & 32'h3);
        wb(1'b1, `REG_CMD, 32'h0, rd);
        // Start refused while rapid stop held, with interrupt
        wb(1'b0, `REG_IRQ_STAT, 32'h0, rd);
        wb(1'b1, `REG_IRQ_MASK, 32'h4, rd);
        chk("irq_idle", 32'h0, {31'h0, irq_o});
        wb(1'b1, `REG_CMD, 32'h2, rd);
        wb(1'b1, `REG_CMD, 32'h6, rd);
        wb(1'b0, `REG_STATUS, 32'h0, rd); chk("refused", 32'h0, rd & 32'h71);
        chk("irq_set", 32'h1, {31'h0, irq_o});
        wb(1'b0, `REG_IRQ_STAT, 32'h0, rd); chk("irq_stat", 32'h4, rd & 32'h4);
        chk("irq_clear", 32'h0, {31'h0, irq_o});
        // Reset in mid-run while the axis moves
        wb(1'b1, `REG_CMD, 32'h0, rd);
        wb(1'b1, `REG_RAPID_TIME, 32'h5, rd);
        wb(1'b1, `REG_CMD, 32'h4, rd);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("rst_speed", 32'h0, {16'h0, speed_cmd_o});
        chk("rst_irq", 32'h0, {31'h0, irq_o});
        wb(1'b0, `REG_RAPID_TIME, 32'h0, rd); chk("rst_time", 32'h64, rd);
        wb(1'b0, `REG_STATUS, 32'h0, rd); chk("rst_status", 32'h0, rd);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        end_of_test();
    end
endmodule // axis_rapid_stop_handler_tb_top
